// ### mie_alu.sv
// shared constants, carrier types and the data path of the executor
`timescale 1ns/100ps
package mie_pkg;
  localparam int         PC_W      = 15;
  localparam int         DW        = 8;
  localparam logic [3:0] BCD_MAX   = 4'h9;
  localparam logic [3:0] BCD_FIX   = 4'h6;
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [7:0] ONE_BYTE  = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;

  // instruction codes of the executed slice
  typedef enum logic [4:0] {
    OP_NOP        = 5'h00,
    OP_PRECLR_1   = 5'h01,
    OP_PRECLR_2   = 5'h02,
    OP_INV_MEM    = 5'h03,
    OP_INV_ACC    = 5'h04,
    OP_DEC_ADJ    = 5'h05,
    OP_DEC_MEM    = 5'h06,
    OP_DEC_ACC    = 5'h07,
    OP_INC_MEM    = 5'h08,
    OP_INC_ACC    = 5'h09,
    OP_HALT       = 5'h0A,
    OP_BRANCH     = 5'h0B,
    OP_MOV_A_M    = 5'h0C,
    OP_MOV_A_X    = 5'h0D,
    OP_MOV_M_A    = 5'h0E,
    OP_OR_A_M     = 5'h0F,
    OP_OR_A_X     = 5'h10,
    OP_OR_MEM     = 5'h11,
    OP_SUB_EXIT   = 5'h12,
    OP_SUB_EXIT_X = 5'h13,
    OP_INT_RETURN = 5'h14,
    OP_ROT_MEM    = 5'h15,
    OP_ROT_ACC    = 5'h16
  } mie_op_t;

  // executor sequencing, one-hot
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_DUMMY = 3'b010,
    ST_HALT  = 3'b100
  } mie_state_t;

  // last pre-clear seen, for the alternation check
  typedef enum logic [1:0] {
    PCL_NONE   = 2'b00,
    PCL_FIRST  = 2'b01,
    PCL_SECOND = 2'b10
  } mie_pcl_t;

  typedef struct packed {
    logic            valid;
    mie_op_t         op;
    logic [7:0]      imm;
    logic [PC_W-1:0] target;
  } mie_instr_t;

  typedef struct packed {
    logic       en;
    logic [7:0] data;
  } mie_mem_wr_t;

  typedef struct packed {
    logic zero;
    logic carry;
    logic watchdog_timeout_flag;
    logic power_down_flag;
    logic master_interrupt_enable;
  } mie_flags_t;
endpackage : mie_pkg

// combinational result of one data instruction
module mie_alu (
  input  wire mie_pkg::mie_op_t op,
  input  wire logic [7:0]       acc,
  input  wire logic [7:0]       mem,
  input  wire logic [7:0]       imm,
  input  wire logic             carry,
  input  wire logic             auxiliary_carry_flag,
  output logic [7:0]            result,
  output logic                  zero,
  output logic                  carry_out
);
  logic       lo_fix;
  logic       hi_fix;
  logic [8:0] adj_sum;

  // decimal correction terms
  always_comb begin
    lo_fix  = (acc[3:0] > mie_pkg::BCD_MAX) || auxiliary_carry_flag;
    hi_fix  = (acc[7:4] > mie_pkg::BCD_MAX) || carry;
    adj_sum = {1'b0, acc} + {1'b0, (hi_fix ? mie_pkg::BCD_FIX : 4'h0),
                             (lo_fix ? mie_pkg::BCD_FIX : 4'h0)};
  end

  // result select per operation
  always_comb begin
    result    = mem;
    carry_out = carry;
    unique case (op)
      mie_pkg::OP_INV_MEM, mie_pkg::OP_INV_ACC: result = ~mem;
      mie_pkg::OP_DEC_MEM, mie_pkg::OP_DEC_ACC: result = mem - mie_pkg::ONE_BYTE;
      mie_pkg::OP_INC_MEM, mie_pkg::OP_INC_ACC: result = mem + mie_pkg::ONE_BYTE;
      mie_pkg::OP_OR_A_M, mie_pkg::OP_OR_MEM:   result = acc | mem;
      mie_pkg::OP_OR_A_X:                       result = acc | imm;
      mie_pkg::OP_ROT_MEM, mie_pkg::OP_ROT_ACC: result = {mem[6:0], mem[7]};
      mie_pkg::OP_MOV_A_X, mie_pkg::OP_SUB_EXIT_X: result = imm;
      mie_pkg::OP_MOV_M_A:                      result = acc;
      mie_pkg::OP_DEC_ADJ: begin
        result    = adj_sum[7:0];
        carry_out = carry | hi_fix | adj_sum[8];
      end
      default:                                  result = mem;
    endcase
    zero = (result == mie_pkg::ZERO_BYTE);
  end
endmodule : mie_alu

// ### mie_exec.sv
// executor for a slice of an 8-bit controller instruction set
//
// Contract
// - either pre-clear acts only right after the other one
// - effective pre-clear clears counter, timeout, power-down
// - otherwise timeout and power-down flags keep value
// - invert memory byte in place, zero flag only
// - invert to accumulator, memory unchanged, zero only
// - low nibble plus six above nine or aux
// - high nibble plus six above nine or carry
// - decimal result to memory, only carry changes
// - decrement memory in place, zero flag only
// - increment memory in place, zero flag only
// - increment or decrement to accumulator, memory unchanged
// - power-down stops execution, keeps all state
// - power-down clears counters, sets power-down, clears timeout
// - branch loads counter, two cycles, no flags
// - moves copy bytes, alter no flag
// - no-operation changes nothing
// - OR to accumulator or memory, zero only
// - subroutine exit reloads counter from stack
// - exit with literal also loads accumulator
// - interrupt return reloads counter, sets enable
// - pending interrupt served before main program
// - rotate left, bit seven into bit zero
`timescale 1ns/100ps

module mie_exec (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire mie_pkg::mie_instr_t           instr,
  input  wire logic [7:0]                    mem_rdata,
  input  wire logic [mie_pkg::PC_W-1:0]      stack_top,
  input  wire logic                          auxiliary_carry_flag,
  input  wire logic                          interrupt_pending,
  input  wire logic                          watchdog_timeout_evt,
  input  wire logic                          wake,
  output logic                               ready,
  output logic [7:0]                         acc,
  output mie_pkg::mie_flags_t                flags,
  output mie_pkg::mie_mem_wr_t               mem_wr,
  output logic [mie_pkg::PC_W-1:0]           pc,
  output logic                               pc_load,
  output logic                               stack_pop,
  output logic                               watchdog_counter_clear,
  output logic                               prescaler_clear,
  output logic                               clock_stop,
  output logic                               interrupt_service
);
  mie_pkg::mie_state_t  state;
  mie_pkg::mie_state_t  next_state;
  mie_pkg::mie_pcl_t    pcl;
  mie_pkg::mie_pcl_t    next_pcl;
  mie_pkg::mie_flags_t  next_flags;
  mie_pkg::mie_mem_wr_t next_mem_wr;
  logic [7:0]           next_acc;
  logic [mie_pkg::PC_W-1:0] next_pc;
  logic                 next_pc_load;
  logic                 next_stack_pop;
  logic                 next_wd_clear;
  logic                 next_presc_clear;
  logic                 next_interrupt_service;
  logic                 take;
  logic [7:0]           alu_result;
  logic                 alu_zero;
  logic                 alu_carry;
  logic                 preclr_hit;

  // shared data path
  mie_alu u_alu (
    .op                   (instr.op),
    .acc                  (acc),
    .mem                  (mem_rdata),
    .imm                  (instr.imm),
    .carry                (flags.carry),
    .auxiliary_carry_flag (auxiliary_carry_flag),
    .result               (alu_result),
    .zero                 (alu_zero),
    .carry_out            (alu_carry)
  );

  // ready is the run bit of the one-hot state
  assign ready      = state[0];
  assign clock_stop = state[2];
  assign take       = instr.valid && (state == mie_pkg::ST_RUN);

  // next values of the whole executor
  always_comb begin
    next_state             = state;
    next_pcl               = pcl;
    next_flags             = flags;
    next_acc               = acc;
    next_pc                = pc;
    next_pc_load           = 1'b0;
    next_stack_pop         = 1'b0;
    next_wd_clear          = 1'b0;
    next_presc_clear       = 1'b0;
    next_interrupt_service = 1'b0;
    next_mem_wr            = '0;
    preclr_hit             = 1'b0;
    unique case (state)
      mie_pkg::ST_RUN: begin
        if (take) begin
          // any other instruction breaks the pre-clear pair
          next_pcl = mie_pkg::PCL_NONE;
          unique case (instr.op)
            mie_pkg::OP_PRECLR_1, mie_pkg::OP_PRECLR_2: begin
              preclr_hit = (instr.op == mie_pkg::OP_PRECLR_1) ?
                           (pcl == mie_pkg::PCL_SECOND) : (pcl == mie_pkg::PCL_FIRST);
              if (preclr_hit) begin
                next_wd_clear                    = 1'b1;
                next_flags.watchdog_timeout_flag = 1'b0;
                next_flags.power_down_flag       = 1'b0;
                next_pcl                         = mie_pkg::PCL_NONE;
              end else begin
                next_pcl = (instr.op == mie_pkg::OP_PRECLR_1) ?
                           mie_pkg::PCL_FIRST : mie_pkg::PCL_SECOND;
              end
            end
            mie_pkg::OP_INV_MEM, mie_pkg::OP_DEC_MEM, mie_pkg::OP_INC_MEM,
            mie_pkg::OP_OR_MEM: begin
              next_mem_wr.en   = 1'b1;
              next_mem_wr.data = alu_result;
              next_flags.zero  = alu_zero;
            end
            mie_pkg::OP_INV_ACC, mie_pkg::OP_DEC_ACC, mie_pkg::OP_INC_ACC,
            mie_pkg::OP_OR_A_M, mie_pkg::OP_OR_A_X: begin
              next_acc        = alu_result;
              next_flags.zero = alu_zero;
            end
            mie_pkg::OP_DEC_ADJ: begin
              next_mem_wr.en   = 1'b1;
              next_mem_wr.data = alu_result;
              next_flags.carry = alu_carry;
            end
            mie_pkg::OP_ROT_MEM, mie_pkg::OP_MOV_M_A: begin
              next_mem_wr.en   = 1'b1;
              next_mem_wr.data = alu_result;
            end
            mie_pkg::OP_ROT_ACC, mie_pkg::OP_MOV_A_M, mie_pkg::OP_MOV_A_X: begin
              next_acc = alu_result;
            end
            mie_pkg::OP_HALT: begin
              next_wd_clear                    = 1'b1;
              next_presc_clear                 = 1'b1;
              next_flags.power_down_flag       = 1'b1;
              next_flags.watchdog_timeout_flag = 1'b0;
              next_state                       = mie_pkg::ST_HALT;
            end
            mie_pkg::OP_BRANCH: begin
              next_pc      = instr.target;
              next_pc_load = 1'b1;
              next_state   = mie_pkg::ST_DUMMY;
            end
            mie_pkg::OP_SUB_EXIT, mie_pkg::OP_SUB_EXIT_X,
            mie_pkg::OP_INT_RETURN: begin
              next_pc        = stack_top;
              next_pc_load   = 1'b1;
              next_stack_pop = 1'b1;
              next_state     = mie_pkg::ST_DUMMY;
              if (instr.op == mie_pkg::OP_SUB_EXIT_X) begin
                next_acc = alu_result;
              end
              if (instr.op == mie_pkg::OP_INT_RETURN) begin
                next_flags.master_interrupt_enable = 1'b1;
                next_interrupt_service = interrupt_pending;
              end
            end
            default: ; // no-operation: nothing moves
          endcase
        end
      end
      mie_pkg::ST_DUMMY: begin
        next_state = mie_pkg::ST_RUN;
      end
      mie_pkg::ST_HALT: begin
        if (wake) begin
          next_state = mie_pkg::ST_RUN;
        end
      end
      default: next_state = mie_pkg::ST_RUN;
    endcase
    // a timeout in the clearing cycle still lands
    if (watchdog_timeout_evt) begin
      next_flags.watchdog_timeout_flag = 1'b1;
    end
  end

  // register stage of the executor
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state                  <= mie_pkg::ST_RUN;
      pcl                    <= mie_pkg::PCL_NONE;
      flags                  <= '0;
      acc                    <= mie_pkg::ACC_RST;
      pc                     <= mie_pkg::PC_RST;
      pc_load                <= 1'b0;
      stack_pop              <= 1'b0;
      watchdog_counter_clear <= 1'b0;
      prescaler_clear        <= 1'b0;
      interrupt_service      <= 1'b0;
      mem_wr                 <= '0;
    end else begin
      state                  <= next_state;
      pcl                    <= next_pcl;
      flags                  <= next_flags;
      acc                    <= next_acc;
      pc                     <= next_pc;
      pc_load                <= next_pc_load;
      stack_pop              <= next_stack_pop;
      watchdog_counter_clear <= next_wd_clear;
      prescaler_clear        <= next_presc_clear;
      interrupt_service      <= next_interrupt_service;
      mem_wr                 <= next_mem_wr;
    end
  end

  // checks on the executor
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_taken(mie_pkg::mie_op_t o);
    take && instr.op == o;
  endsequence

  sequence s_two_cycle_redirect;
    pc_load && !stack_pop && !ready ##1 ready;
  endsequence

  property p_preclr_repeat;
    s_taken(mie_pkg::OP_PRECLR_2) ##1 s_taken(mie_pkg::OP_PRECLR_2) |=> !watchdog_counter_clear;
  endproperty
  a_preclr_repeat: assert property (p_preclr_repeat) else $error("repeated pre-clear acted");

  property p_preclr_pair;
    s_taken(mie_pkg::OP_PRECLR_1) ##0 pcl != mie_pkg::PCL_SECOND
      ##1 s_taken(mie_pkg::OP_PRECLR_2) ##0 !watchdog_timeout_evt
      |=> watchdog_counter_clear && !flags.watchdog_timeout_flag && !flags.power_down_flag;
  endproperty
  a_preclr_pair: assert property (p_preclr_pair) else $error("pre-clear pair missed");

  property p_preclr_keep;
    (take && pcl == mie_pkg::PCL_NONE && instr.op == mie_pkg::OP_PRECLR_1 && !watchdog_timeout_evt)
      |=> $stable(flags.power_down_flag) && $stable(flags.watchdog_timeout_flag);
  endproperty
  a_preclr_keep: assert property (p_preclr_keep) else $error("lone pre-clear moved flags");

  property p_invert;
    s_taken(mie_pkg::OP_INV_MEM) |=> mem_wr.en && mem_wr.data == ~$past(mem_rdata)
      && flags.zero == ($past(mem_rdata) == 8'hFF) && $stable(acc);
  endproperty
  a_invert: assert property (p_invert) else $error("in-place invert wrong");

  property p_inc_acc;
    s_taken(mie_pkg::OP_INC_ACC) |=> !mem_wr.en && acc == $past(mem_rdata) + 8'h01
      && flags.zero == (acc == 8'h00);
  endproperty
  a_inc_acc: assert property (p_inc_acc) else $error("increment to accumulator wrong");

  property p_bcd_plain;
    (s_taken(mie_pkg::OP_DEC_ADJ) && !flags.carry && !auxiliary_carry_flag
      && acc[3:0] <= 4'h9 && acc[7:4] <= 4'h9) |=> mem_wr.data == $past(acc) && !flags.carry;
  endproperty
  a_bcd_plain: assert property (p_bcd_plain) else $error("decimal adjust altered valid bcd");

  property p_bcd_high;
    (s_taken(mie_pkg::OP_DEC_ADJ) && acc[7:4] > 4'h9) |=> flags.carry && mem_wr.en
      && $stable(flags.zero);
  endproperty
  a_bcd_high: assert property (p_bcd_high) else $error("decimal adjust carry missing");

  property p_branch;
    s_taken(mie_pkg::OP_BRANCH) ##0 !watchdog_timeout_evt |=> pc == $past(instr.target)
      and s_two_cycle_redirect
      and $stable(flags);
  endproperty
  a_branch: assert property (p_branch) else $error("branch not two cycles");

  property p_halt;
    s_taken(mie_pkg::OP_HALT) ##0 !watchdog_timeout_evt |=> clock_stop && prescaler_clear
      && flags.power_down_flag && !flags.watchdog_timeout_flag;
  endproperty
  a_halt: assert property (p_halt) else $error("power-down entry wrong");

  property p_int_return;
    s_taken(mie_pkg::OP_INT_RETURN) |=> stack_pop && pc == $past(stack_top)
      && flags.master_interrupt_enable && interrupt_service == $past(interrupt_pending);
  endproperty
  a_int_return: assert property (p_int_return) else $error("interrupt return wrong");

  property p_nop;
    s_taken(mie_pkg::OP_NOP) ##0 !watchdog_timeout_evt |=> $stable(acc) && $stable(flags)
      && !mem_wr.en && ready;
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation changed state");

  property p_invert_acc;
    s_taken(mie_pkg::OP_INV_ACC) |=> !mem_wr.en && acc == ~$past(mem_rdata)
      && flags.zero == (acc == 8'h00);
  endproperty
  a_invert_acc: assert property (p_invert_acc) else $error("invert to acc wrong");

  property p_move_imm;
    s_taken(mie_pkg::OP_MOV_A_X) ##0 !watchdog_timeout_evt |=> acc == $past(instr.imm)
      && $stable(flags) && !mem_wr.en;
  endproperty
  a_move_imm: assert property (p_move_imm) else $error("move immediate wrong");

  property p_rotate_mem;
    s_taken(mie_pkg::OP_ROT_MEM) ##0 !watchdog_timeout_evt |=> mem_wr.en && $stable(flags)
      && mem_wr.data == {$past(mem_rdata[6:0]), $past(mem_rdata[7])} && $stable(acc);
  endproperty
  a_rotate_mem: assert property (p_rotate_mem) else $error("rotate left wrong");

  property p_sub_exit;
    s_taken(mie_pkg::OP_SUB_EXIT) ##0 !watchdog_timeout_evt |=> stack_pop && pc_load
      && pc == $past(stack_top) && $stable(flags) && $stable(acc);
  endproperty
  a_sub_exit: assert property (p_sub_exit) else $error("subroutine exit wrong");
endmodule : mie_exec

// ### mie_exec_tb.sv
// self-checking bench for the instruction slice executor
`timescale 1ns/100ps

module mie_exec_tb;
  logic                     clk;
  logic                     sys_rst;
  mie_pkg::mie_instr_t      instr;
  logic [7:0]               mem_rdata;
  logic [mie_pkg::PC_W-1:0] stack_top;
  logic                     auxiliary_carry_flag;
  logic                     interrupt_pending;
  logic                     watchdog_timeout_evt;
  logic                     wake;
  logic                     ready;
  logic [7:0]               acc;
  mie_pkg::mie_flags_t      flags;
  mie_pkg::mie_mem_wr_t     mem_wr;
  logic [mie_pkg::PC_W-1:0] pc;
  logic                     pc_load;
  logic                     stack_pop;
  logic                     wdc;
  logic                     psc;
  logic                     clock_stop;
  logic                     interrupt_service;
  int                       bad_count;
  int                       compares;
  logic [7:0]               ea;
  mie_pkg::mie_flags_t      ef;

  mie_exec uut (
    .clk                    (clk),
    .sys_rst                (sys_rst),
    .instr                  (instr),
    .mem_rdata              (mem_rdata),
    .stack_top              (stack_top),
    .auxiliary_carry_flag   (auxiliary_carry_flag),
    .interrupt_pending      (interrupt_pending),
    .watchdog_timeout_evt   (watchdog_timeout_evt),
    .wake                   (wake),
    .ready                  (ready),
    .acc                    (acc),
    .flags                  (flags),
    .mem_wr                 (mem_wr),
    .pc                     (pc),
    .pc_load                (pc_load),
    .stack_pop              (stack_pop),
    .watchdog_counter_clear (wdc),
    .prescaler_clear        (psc),
    .clock_stop             (clock_stop),
    .interrupt_service      (interrupt_service)
  );

  // free-running clock, 4 ns period
  always #2 clk = ~clk;

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // present one instruction, judge the state at the falling edge half a cycle after the take edge
  task automatic step(input mie_pkg::mie_op_t op, input logic [7:0] m, input logic [7:0] x,
                      input logic wen, input logic [7:0] wd);
    instr.valid = 1'b1;
    instr.op    = op;
    instr.imm   = x;
    mem_rdata   = m;
    @(negedge clk);
    chk("acc", 16'(ea), 16'(acc));
    chk("flags", 16'(ef), 16'(flags));
    chk("mem_wr_en", 16'(wen), 16'(mem_wr.en));
    if (wen) begin
      chk("mem_wr_data", 16'(wd), 16'(mem_wr.data));
    end
    if (!(op inside {mie_pkg::OP_BRANCH, mie_pkg::OP_SUB_EXIT, mie_pkg::OP_SUB_EXIT_X,
                     mie_pkg::OP_INT_RETURN, mie_pkg::OP_HALT})) begin
      chk("ready", 16'h0001, 16'(ready));
      chk("pc_load", 16'h0000, 16'(pc_load));
    end
  endtask : step

  task automatic idle(input int n);
    instr.valid = 1'b0;
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic t_move;
    step(mie_pkg::OP_MOV_A_X, 8'hFF, 8'h00, 1'b0, 8'h00);
    ea = 8'h5A;
    step(mie_pkg::OP_MOV_A_X, 8'h00, 8'h5A, 1'b0, 8'h00);
    step(mie_pkg::OP_MOV_M_A, 8'h11, 8'hEE, 1'b1, 8'h5A);
    ea = 8'hC3;
    step(mie_pkg::OP_MOV_A_M, 8'hC3, 8'h00, 1'b0, 8'h00);
    step(mie_pkg::OP_NOP, 8'h77, 8'h77, 1'b0, 8'h00);
  endtask : t_move

  task automatic t_arith;
    ea = 8'h00;
    ef.zero = 1'b1;
    step(mie_pkg::OP_INV_ACC, 8'hFF, 8'h00, 1'b0, 8'h00);
    ef.zero = 1'b0;
    step(mie_pkg::OP_INV_MEM, 8'h0F, 8'h00, 1'b1, 8'hF0);
    ef.zero = 1'b1;
    step(mie_pkg::OP_INV_MEM, 8'hFF, 8'h00, 1'b1, 8'h00);
    step(mie_pkg::OP_DEC_MEM, 8'h01, 8'h00, 1'b1, 8'h00);
    ef.zero = 1'b0;
    step(mie_pkg::OP_DEC_MEM, 8'h00, 8'h00, 1'b1, 8'hFF);
    ef.zero = 1'b1;
    step(mie_pkg::OP_INC_MEM, 8'hFF, 8'h00, 1'b1, 8'h00);
    ea = 8'hFF;
    ef.zero = 1'b0;
    step(mie_pkg::OP_DEC_ACC, 8'h00, 8'h00, 1'b0, 8'h00);
    ea = 8'h00;
    ef.zero = 1'b1;
    step(mie_pkg::OP_INC_ACC, 8'hFF, 8'h00, 1'b0, 8'h00);
    ea = 8'h80;
    ef.zero = 1'b0;
    step(mie_pkg::OP_INC_ACC, 8'h7F, 8'h00, 1'b0, 8'h00);
  endtask : t_arith

  task automatic t_bcd_adjust;
    logic [7:0] a_in [5] = '{8'h12, 8'h1C, 8'h13, 8'hA0, 8'h12};
    logic       ax   [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    logic [7:0] res  [5] = '{8'h12, 8'h22, 8'h19, 8'h00, 8'h72};
    logic       cy   [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 5; i++) begin
      ea = a_in[i];
      step(mie_pkg::OP_MOV_A_X, 8'h00, a_in[i], 1'b0, 8'h00);
      auxiliary_carry_flag = ax[i];
      ef.carry = cy[i];
      step(mie_pkg::OP_DEC_ADJ, 8'h00, 8'h00, 1'b1, res[i]);
    end
    auxiliary_carry_flag = 1'b0;
  endtask : t_bcd_adjust

  task automatic t_or_rot;
    ea = 8'hF0;
    step(mie_pkg::OP_MOV_A_X, 8'h00, 8'hF0, 1'b0, 8'h00);
    ea = 8'hFF;
    step(mie_pkg::OP_OR_A_X, 8'h00, 8'h0F, 1'b0, 8'h00);
    ea = 8'h00;
    step(mie_pkg::OP_MOV_A_X, 8'h00, 8'h00, 1'b0, 8'h00);
    ef.zero = 1'b1;
    step(mie_pkg::OP_OR_A_M, 8'h00, 8'hFF, 1'b0, 8'h00);
    ea = 8'h30;
    step(mie_pkg::OP_MOV_A_X, 8'h00, 8'h30, 1'b0, 8'h00);
    ef.zero = 1'b0;
    step(mie_pkg::OP_OR_MEM, 8'h03, 8'h00, 1'b1, 8'h33);
    step(mie_pkg::OP_ROT_MEM, 8'h81, 8'h00, 1'b1, 8'h03);
    ea = 8'h81;
    step(mie_pkg::OP_ROT_ACC, 8'hC0, 8'h00, 1'b0, 8'h00);
  endtask : t_or_rot

  task automatic t_branch;
    instr.target = 15'h1234;
    step(mie_pkg::OP_BRANCH, 8'h00, 8'h00, 1'b0, 8'h00);
    chk("pc", 16'h1234, 16'(pc));
    chk("pc_load", 16'h0001, 16'(pc_load));
    chk("ready", 16'h0000, 16'(ready));
    instr.op  = mie_pkg::OP_MOV_A_X;
    instr.imm = 8'h77;
    @(negedge clk);
    chk("acc", 16'(ea), 16'(acc));
    chk("ready", 16'h0001, 16'(ready));
    @(negedge clk);
    ea = 8'h77;
    chk("acc", 16'(ea), 16'(acc));
    idle(1);
  endtask : t_branch

  task automatic t_return;
    stack_top = 15'h0ABC;
    step(mie_pkg::OP_SUB_EXIT, 8'h00, 8'h00, 1'b0, 8'h00);
    chk("pc", 16'h0ABC, 16'(pc));
    chk("stack_pop", 16'h0001, 16'(stack_pop));
    idle(1);
    stack_top = 15'h1555;
    ea = 8'h3C;
    step(mie_pkg::OP_SUB_EXIT_X, 8'h00, 8'h3C, 1'b0, 8'h00);
    chk("pc", 16'h1555, 16'(pc));
    idle(1);
    stack_top = 15'h0321;
    ef.master_interrupt_enable = 1'b1;
    step(mie_pkg::OP_INT_RETURN, 8'h00, 8'h00, 1'b0, 8'h00);
    chk("pc", 16'h0321, 16'(pc));
    idle(1);
    chk("int_service", 16'h0000, 16'(interrupt_service));
    interrupt_pending = 1'b1;
    step(mie_pkg::OP_INT_RETURN, 8'h00, 8'h00, 1'b0, 8'h00);
    chk("int_service", 16'h0001, 16'(interrupt_service));
    idle(1);
    chk("int_service", 16'h0000, 16'(interrupt_service));
    interrupt_pending = 1'b0;
  endtask : t_return

  task automatic timeout_pulse;
    instr.valid = 1'b0;
    watchdog_timeout_evt = 1'b1;
    @(negedge clk);
    watchdog_timeout_evt = 1'b0;
    @(negedge clk);
    ef.watchdog_timeout_flag = 1'b1;
    chk("flags", 16'(ef), 16'(flags));
  endtask : timeout_pulse

  task automatic t_halt;
    timeout_pulse();
    ef.watchdog_timeout_flag = 1'b0;
    ef.power_down_flag = 1'b1;
    step(mie_pkg::OP_HALT, 8'h00, 8'h00, 1'b0, 8'h00);
    chk("clock_stop", 16'h0001, 16'(clock_stop));
    chk("wd_clear", 16'h0001, 16'(wdc));
    chk("presc_clear", 16'h0001, 16'(psc));
    instr.op  = mie_pkg::OP_MOV_A_X;
    instr.imm = 8'h55;
    repeat (3) @(negedge clk);
    chk("acc", 16'(ea), 16'(acc));
    chk("clock_stop", 16'h0001, 16'(clock_stop));
    instr.valid = 1'b0;
    wake = 1'b1;
    for (int i = 0; i < 8 && ready !== 1'b1; i++) @(negedge clk);
    wake = 1'b0;
    chk("ready", 16'h0001, 16'(ready));
    chk("flags", 16'(ef), 16'(flags));
  endtask : t_halt

  task automatic t_preclear;
    timeout_pulse();
    step(mie_pkg::OP_PRECLR_1, 8'h00, 8'h00, 1'b0, 8'h00);
    step(mie_pkg::OP_NOP, 8'h00, 8'h00, 1'b0, 8'h00);
    step(mie_pkg::OP_PRECLR_2, 8'h00, 8'h00, 1'b0, 8'h00);
    chk("wd_clear", 16'h0000, 16'(wdc));
    step(mie_pkg::OP_PRECLR_2, 8'h00, 8'h00, 1'b0, 8'h00);
    chk("wd_clear", 16'h0000, 16'(wdc));
    ef.watchdog_timeout_flag = 1'b0;
    ef.power_down_flag = 1'b0;
    step(mie_pkg::OP_PRECLR_1, 8'h00, 8'h00, 1'b0, 8'h00);
    chk("wd_clear", 16'h0001, 16'(wdc));
    // first then second, back to back, also acts
    timeout_pulse();
    step(mie_pkg::OP_PRECLR_1, 8'h00, 8'h00, 1'b0, 8'h00);
    chk("wd_clear", 16'h0000, 16'(wdc));
    ef.watchdog_timeout_flag = 1'b0;
    step(mie_pkg::OP_PRECLR_2, 8'h00, 8'h00, 1'b0, 8'h00);
    chk("wd_clear", 16'h0001, 16'(wdc));
    idle(1);
  endtask : t_preclear

  task automatic tally_and_finish;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // cut a hang short well after the expected run of about 70 cycles
  initial begin
    #20000;
    bad_count++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    instr = '0;
    mem_rdata = 8'h00;
    stack_top = '0;
    auxiliary_carry_flag = 1'b0;
    interrupt_pending = 1'b0;
    watchdog_timeout_evt = 1'b0;
    wake = 1'b0;
    bad_count = 0;
    compares = 0;
    ea = 8'h00;
    ef = '0;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    chk("ready", 16'h0001, 16'(ready));
    chk("acc", 16'h0000, 16'(acc));
    chk("pc", 16'h0000, 16'(pc));
    chk("flags", 16'h0000, 16'(flags));
    t_move();
    t_arith();
    t_bcd_adjust();
    t_or_rot();
    t_branch();
    t_return();
    t_halt();
    t_preclear();
    tally_and_finish();
  end
endmodule : mie_exec_tb
